/* File: pin_mux_pkg.sv */
// constants, modes and carrier types for the printer / extension floppy pin mux
// What this block does
// - global and parport config pick the pin use
// - busy high means printer cannot take data
// - acknowledge low means byte taken, ready
// - fault low means printer reports error
// - strobe pulses low to latch data byte
// - auto-feed low advances; select-in, initialise open-drain
// - single mode maps drive B signals
// - step, direction, density on select-in, initialise, auto-feed
// - index, track zero, protect from data 0-2
// - strobe floats in either floppy use
// - direction high outward, low inward
// - head select high side 0, low side 1
// - motor outputs low enable drives 0, 1
// - drive selects low enable drives A, B
// - one low step pulse per track move
// - open-drain write data, write enable
// - floppy pull-ups, disabled by config bit 7; data 0-4 pull-ups follow floppy use only
// - read data, change from data 3-4; 5 floats
// - dual drives motor A, select A on 6-7
package pin_mux_pkg;

    // *****************************************************
    // configuration bit positions
    // *****************************************************
    localparam int EXT_ENABLE_BIT = 4;   // global_port_mode_reg: extension use on
    localparam int EXT_DUAL_BIT   = 3;   // parport_device_config_reg: dual drives
    localparam int PULLUP_DIS_BIT = 7;   // floppy_device_config_reg: floppy_pullup_disable

    // *****************************************************
    // data line roles in floppy use
    // *****************************************************
    localparam int DL_INDEX   = 0;
    localparam int DL_TRACK0  = 1;
    localparam int DL_PROTECT = 2;
    localparam int DL_RDATA   = 3;
    localparam int DL_CHANGE  = 4;
    localparam int DL_SPARE   = 5;
    localparam int DL_MOTOR_A = 6;
    localparam int DL_SEL_A   = 7;
    localparam int DATA_W     = 8;
    localparam int SENSE_W    = 5;
    localparam int STAT_W     = 5;

    // idle levels of pulled-up inputs
    localparam logic [DATA_W-1:0]  DATA_IDLE  = 8'hff;
    localparam logic [STAT_W-1:0]  STAT_IDLE  = 5'h1f;

    // *****************************************************
    // modes and carriers
    // *****************************************************
    typedef enum logic [1:0] {
        MODE_PRINTER,
        MODE_EXT_SINGLE,
        MODE_EXT_DUAL
    } port_mode_t;

    // floppy controller outputs, all active-low levels
    typedef struct packed {
        logic motor_a_on;
        logic motor_b_on;
        logic drive_select_a;
        logic drive_select_b;
        logic step_direction;
        logic step_pulse;
        logic write_data_out;
        logic write_enable_out;
        logic side_select;
        logic density_select_bit0;
    } fdc_drive_t;

    // sense lines back to the floppy controller
    typedef struct packed {
        logic index_hole_in;
        logic track_zero_in;
        logic write_protect_in;
        logic read_data_in;
        logic disk_change_in;
    } fdc_sense_t;

    localparam fdc_sense_t SENSE_IDLE = 5'h1f;

    // parallel port logic outputs toward the pins
    typedef struct packed {
        logic              printer_strobe;
        logic              printer_auto_feed;
        logic              printer_select_in;
        logic              printer_initialise;
        logic              data_drive;
        logic [DATA_W-1:0] data_out;
    } prn_ctrl_t;

    // printer status toward the parallel port logic
    typedef struct packed {
        logic              not_ready;
        logic              ack_taken;
        logic              fault;
        logic              selected;
        logic              paper_out;
        logic [DATA_W-1:0] data_in;
    } prn_status_t;

endpackage : pin_mux_pkg

/* File: sync_2ff.sv */
// two flip-flop synchroniser for pin inputs
`timescale 1ns/100ps
module sync_2ff #(
    parameter int               WIDTH    = 1,
    parameter logic [WIDTH-1:0] IDLE_VAL = '1
) (
    input  wire logic             ref_clk,
    input  wire logic             reset,
    input  wire logic [WIDTH-1:0] async_in,
    output logic      [WIDTH-1:0] sync_out
);
    logic [WIDTH-1:0] meta_ff;
    logic [WIDTH-1:0] sync_ff;

    generate
        if (WIDTH < 1) begin : g_bad_width
            $error("sync_2ff width must be at least one");
        end
    endgenerate

    // first stage feeds only the second stage
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            meta_ff <= IDLE_VAL;
            sync_ff <= IDLE_VAL;
        end else begin
            meta_ff <= async_in;
            sync_ff <= meta_ff;
        end
    end

    assign sync_out = sync_ff;

endmodule : sync_2ff

/* File: od_pin.sv */
// registered open-drain pad driver
`timescale 1ns/100ps
module od_pin (
    input  wire logic ref_clk,
    input  wire logic reset,
    input  wire logic enable,
    input  wire logic level,
    output logic      pad_o,
    output logic      pad_oe
);
    logic oe_ff;
    logic out_ff;

    // pull low only while enabled and the level is low; float otherwise
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            oe_ff  <= 1'b0;
            out_ff <= 1'b0;
        end else begin
            oe_ff  <= enable & ~level;
            out_ff <= 1'b0;
        end
    end

    assign pad_o  = out_ff;
    assign pad_oe = oe_ff;

endmodule : od_pin

/* File: printer_floppy_pin_mux.sv */
// pin steering between printer use and extension floppy use of the parallel connector
`timescale 1ns/100ps
module printer_floppy_pin_mux (
    input  wire logic                     ref_clk,
    input  wire logic                     reset,
    input  wire logic [7:0]               global_port_mode_reg,
    input  wire logic [7:0]               parport_device_config_reg,
    input  wire logic [7:0]               floppy_device_config_reg,
    input  wire pin_mux_pkg::fdc_drive_t  fdc_drive,
    output pin_mux_pkg::fdc_sense_t       fdc_sense,
    output logic                          fdc_pullup_en,
    input  wire pin_mux_pkg::prn_ctrl_t   prn_ctrl,
    output pin_mux_pkg::prn_status_t      prn_status,
    input  wire logic                     printer_select_i,
    output logic                          printer_select_o,
    output logic                          printer_select_oe,
    input  wire logic                     paper_end_i,
    output logic                          paper_end_o,
    output logic                          paper_end_oe,
    input  wire logic                     busy_i,
    output logic                          busy_o,
    output logic                          busy_oe,
    input  wire logic                     printer_acknowledge_i,
    output logic                          printer_acknowledge_o,
    output logic                          printer_acknowledge_oe,
    input  wire logic                     printer_fault_i,
    output logic                          printer_fault_o,
    output logic                          printer_fault_oe,
    output logic                          printer_select_in_o,
    output logic                          printer_select_in_oe,
    output logic                          printer_initialise_o,
    output logic                          printer_initialise_oe,
    output logic                          printer_auto_feed_o,
    output logic                          printer_auto_feed_oe,
    output logic                          printer_strobe_o,
    output logic                          printer_strobe_oe,
    input  wire logic [7:0]               par_data_i,
    output logic      [7:0]               par_data_o,
    output logic      [7:0]               par_data_oe,
    output logic      [4:0]               par_data_pullup_en
);
    import pin_mux_pkg::*;

    // *****************************************************
    // mode selection
    // *****************************************************
    port_mode_t mode_ff;
    port_mode_t nxt_mode;
    wire        ext_req  = global_port_mode_reg[EXT_ENABLE_BIT];
    wire        dual_req = parport_device_config_reg[EXT_DUAL_BIT];

    // decode of the two config registers
    always_comb begin
        nxt_mode = MODE_PRINTER;
        if (ext_req) begin
            nxt_mode = dual_req ? MODE_EXT_DUAL : MODE_EXT_SINGLE;
        end
    end

    // mode follows config each cycle, so clearing returns to printer use
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            mode_ff <= MODE_PRINTER;
        end else begin
            mode_ff <= nxt_mode;
        end
    end

    wire is_prn  = (mode_ff == MODE_PRINTER);
    wire is_ext  = (mode_ff == MODE_EXT_SINGLE) || (mode_ff == MODE_EXT_DUAL);
    wire is_dual = (mode_ff == MODE_EXT_DUAL);

    // *****************************************************
    // pin input synchronisers
    // *****************************************************
    logic [DATA_W-1:0] data_sync;
    logic [STAT_W-1:0] stat_sync;
    wire  [STAT_W-1:0] stat_raw = {printer_select_i, paper_end_i, busy_i,
                                   printer_acknowledge_i, printer_fault_i};

    sync_2ff #(.WIDTH(DATA_W), .IDLE_VAL(DATA_IDLE)) u_data_sync (
        .ref_clk  (ref_clk),
        .reset    (reset),
        .async_in (par_data_i),
        .sync_out (data_sync)
    );
    sync_2ff #(.WIDTH(STAT_W), .IDLE_VAL(STAT_IDLE)) u_stat_sync (
        .ref_clk  (ref_clk),
        .reset    (reset),
        .async_in (stat_raw),
        .sync_out (stat_sync)
    );

    wire sel_s, paper_s, busy_s, ack_s, fault_s;
    assign {sel_s, paper_s, busy_s, ack_s, fault_s} = stat_sync;  // same order as stat_raw

    // *****************************************************
    // status pins: printer inputs, floppy open-drain outputs
    // *****************************************************
    od_pin u_select_pin (
        .ref_clk (ref_clk),
        .reset   (reset),
        .enable  (is_ext),
        .level   (fdc_drive.write_enable_out),
        .pad_o   (printer_select_o),
        .pad_oe  (printer_select_oe)
    );
    od_pin u_paper_pin (
        .ref_clk (ref_clk),
        .reset   (reset),
        .enable  (is_ext),
        .level   (fdc_drive.write_data_out),
        .pad_o   (paper_end_o),
        .pad_oe  (paper_end_oe)
    );
    od_pin u_busy_pin (
        .ref_clk (ref_clk),
        .reset   (reset),
        .enable  (is_ext),
        .level   (fdc_drive.motor_b_on),
        .pad_o   (busy_o),
        .pad_oe  (busy_oe)
    );
    od_pin u_ack_pin (
        .ref_clk (ref_clk),
        .reset   (reset),
        .enable  (is_ext),
        .level   (fdc_drive.drive_select_b),
        .pad_o   (printer_acknowledge_o),
        .pad_oe  (printer_acknowledge_oe)
    );
    od_pin u_fault_pin (
        .ref_clk (ref_clk),
        .reset   (reset),
        .enable  (is_ext),
        .level   (fdc_drive.side_select),
        .pad_o   (printer_fault_o),
        .pad_oe  (printer_fault_oe)
    );

    // *****************************************************
    // control pins: always open-drain; select-in, initialise, auto-feed take their source by mode, strobe is enabled only in printer use
    // *****************************************************
    wire lvl_sel_in = is_ext ? fdc_drive.step_pulse     : prn_ctrl.printer_select_in;
    wire lvl_init   = is_ext ? fdc_drive.step_direction : prn_ctrl.printer_initialise;
    wire lvl_afd    = is_ext ? fdc_drive.density_select_bit0 : prn_ctrl.printer_auto_feed;

    od_pin u_sel_in_pin (
        .ref_clk (ref_clk),
        .reset   (reset),
        .enable  (1'b1),
        .level   (lvl_sel_in),
        .pad_o   (printer_select_in_o),
        .pad_oe  (printer_select_in_oe)
    );
    od_pin u_init_pin (
        .ref_clk (ref_clk),
        .reset   (reset),
        .enable  (1'b1),
        .level   (lvl_init),
        .pad_o   (printer_initialise_o),
        .pad_oe  (printer_initialise_oe)
    );
    od_pin u_afd_pin (
        .ref_clk (ref_clk),
        .reset   (reset),
        .enable  (1'b1),
        .level   (lvl_afd),
        .pad_o   (printer_auto_feed_o),
        .pad_oe  (printer_auto_feed_oe)
    );
    // strobe floats whenever a floppy use owns the connector
    od_pin u_strobe_pin (
        .ref_clk (ref_clk),
        .reset   (reset),
        .enable  (is_prn),
        .level   (prn_ctrl.printer_strobe),
        .pad_o   (printer_strobe_o),
        .pad_oe  (printer_strobe_oe)
    );

    // *****************************************************
    // data lines
    // *****************************************************
    logic [DATA_W-1:0] data_o_ff;
    logic [DATA_W-1:0] data_oe_ff;
    logic [DATA_W-1:0] nxt_data_o;
    logic [DATA_W-1:0] nxt_data_oe;

    // printer use drives the byte; floppy use reads 0-4, floats 5, 6-7 per mode
    always_comb begin
        nxt_data_o  = prn_ctrl.data_out;
        nxt_data_oe = {DATA_W{prn_ctrl.data_drive}};
        if (is_ext) begin
            nxt_data_o  = '0;
            nxt_data_oe = '0;
            if (is_dual) begin
                nxt_data_oe[DL_MOTOR_A] = ~fdc_drive.motor_a_on;
                nxt_data_oe[DL_SEL_A]   = ~fdc_drive.drive_select_a;
            end
        end
    end

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            data_o_ff  <= '0;
            data_oe_ff <= '0;
        end else begin
            data_o_ff  <= nxt_data_o;
            data_oe_ff <= nxt_data_oe;
        end
    end

    assign par_data_o  = data_o_ff;
    assign par_data_oe = data_oe_ff;

    // *****************************************************
    // sense lines and pull-ups toward the floppy controller
    // *****************************************************
    fdc_sense_t sense_ff;
    fdc_sense_t nxt_sense;
    logic       pullup_ff;
    logic [4:0] data_pu_ff;
    wire        pu_on = ~floppy_device_config_reg[PULLUP_DIS_BIT];

    // data lines carry the drive sense only in floppy use, else idle high
    always_comb begin
        nxt_sense = SENSE_IDLE;
        if (is_ext) begin
            nxt_sense.index_hole_in    = data_sync[DL_INDEX];
            nxt_sense.track_zero_in    = data_sync[DL_TRACK0];
            nxt_sense.write_protect_in = data_sync[DL_PROTECT];
            nxt_sense.read_data_in     = data_sync[DL_RDATA];
            nxt_sense.disk_change_in   = data_sync[DL_CHANGE];
        end
    end

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            sense_ff   <= SENSE_IDLE;
            pullup_ff  <= 1'b1;
            data_pu_ff <= '0;
        end else begin
            sense_ff   <= nxt_sense;
            pullup_ff  <= pu_on;
            data_pu_ff <= {5{is_ext}};
        end
    end

    assign fdc_sense          = sense_ff;
    assign fdc_pullup_en      = pullup_ff;
    assign par_data_pullup_en = data_pu_ff;

    // *****************************************************
    // printer status toward the parallel port logic
    // *****************************************************
    prn_status_t status_ff;
    prn_status_t nxt_status;
    logic        ack_prev_ff;
    wire         ack_fall = ack_prev_ff & ~ack_s;

    // outside printer use the printer reads as not ready and silent
    always_comb begin
        nxt_status           = '0;
        nxt_status.not_ready = 1'b1;
        nxt_status.data_in   = data_sync;
        if (is_prn) begin
            nxt_status.not_ready = busy_s;
            nxt_status.ack_taken = ack_fall;
            nxt_status.fault     = ~fault_s;
            nxt_status.selected  = sel_s;
            nxt_status.paper_out = paper_s;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            status_ff   <= '0;
            ack_prev_ff <= 1'b1;
        end else begin
            status_ff   <= nxt_status;
            ack_prev_ff <= ack_s;
        end
    end

    assign prn_status = status_ff;

    // *****************************************************
    // assertions
    // *****************************************************
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (reset);

    a_mode_follows_cfg: assert property (
        ext_req && dual_req |=> mode_ff == MODE_EXT_DUAL)
        else $error("dual request did not select dual mode");
    a_mode_returns: assert property (
        !ext_req |=> mode_ff == MODE_PRINTER
            ##1 printer_strobe_oe == $past(!prn_ctrl.printer_strobe))
        else $error("printer use not restored");
    a_strobe_float: assert property (
        is_ext |=> !printer_strobe_oe)
        else $error("strobe driven in floppy use");
    a_strobe_pulse: assert property (
        is_prn && !prn_ctrl.printer_strobe |=> printer_strobe_oe && !printer_strobe_o)
        else $error("strobe not pulled low");
    a_step_copy: assert property (
        is_ext |=> printer_select_in_oe == !$past(fdc_drive.step_pulse))
        else $error("step pulse not on select-in");
    a_dir_copy: assert property (
        is_ext |=> printer_initialise_oe == !$past(fdc_drive.step_direction))
        else $error("direction not on initialise");
    a_density_copy: assert property (
        is_ext |=> printer_auto_feed_oe == !$past(fdc_drive.density_select_bit0))
        else $error("density not on auto-feed");
    a_autofeed_prn: assert property (
        is_prn && !prn_ctrl.printer_auto_feed |=> printer_auto_feed_oe)
        else $error("auto-feed not pulled low");
    a_we_copy: assert property (
        is_ext |=> printer_select_oe == !$past(fdc_drive.write_enable_out)
            && paper_end_oe == !$past(fdc_drive.write_data_out))
        else $error("write lines not on select and paper-end");
    a_drive_b_copy: assert property (
        is_ext |=> busy_oe == !$past(fdc_drive.motor_b_on)
            && printer_acknowledge_oe == !$past(fdc_drive.drive_select_b))
        else $error("drive B lines not mapped");
    a_head_copy: assert property (
        is_ext |=> printer_fault_oe == !$past(fdc_drive.side_select))
        else $error("side select not on fault pin");
    a_status_float: assert property (
        is_prn |=> !busy_oe && !printer_acknowledge_oe && !printer_fault_oe)
        else $error("status pin driven in printer use");
    a_single_float: assert property (
        mode_ff == MODE_EXT_SINGLE |=> par_data_oe[7:5] == 3'h0)
        else $error("data 5-7 driven in single use");
    a_dual_motor_a: assert property (
        is_dual |=> par_data_oe[DL_SEL_A] == !$past(fdc_drive.drive_select_a)
            && par_data_oe[DL_MOTOR_A] == !$past(fdc_drive.motor_a_on))
        else $error("drive A lines not on data 6-7");
    a_sense_index: assert property (
        is_ext |=> fdc_sense.index_hole_in == $past(data_sync[DL_INDEX])
            && fdc_sense.write_protect_in == $past(data_sync[DL_PROTECT]))
        else $error("sense lines not taken from data");
    a_sense_change: assert property (
        is_ext |=> fdc_sense.disk_change_in == $past(data_sync[DL_CHANGE])
            && par_data_oe[DL_SPARE] == 1'b0)
        else $error("change line or spare line wrong");
    a_pullup_cut: assert property (
        floppy_device_config_reg[PULLUP_DIS_BIT] |=> !fdc_pullup_en)
        else $error("pull-ups not disabled");
    a_busy_block: assert property (
        is_prn && busy_s |=> prn_status.not_ready)
        else $error("busy printer reported ready");
    a_ack_pulse: assert property (
        prn_status.ack_taken |=> !prn_status.ack_taken)
        else $error("acknowledge pulse longer than a cycle");
    a_fault_flag: assert property (
        is_prn && !fault_s |=> prn_status.fault)
        else $error("fault low not reported");

    c_printer_strobe: cover property (is_prn && printer_strobe_oe);
    c_ext_single:     cover property (mode_ff == MODE_EXT_SINGLE && printer_select_in_oe);
    c_ext_dual:       cover property (is_dual && par_data_oe[DL_SEL_A]);
    c_mode_return:    cover property (is_ext ##1 is_prn);

endmodule : printer_floppy_pin_mux

/* File: far_side_model.sv */
// far side model: printer or extension drives on the connector
`timescale 1ns/100ps
module far_side_model (
    input  wire logic [4:0] stat_lvl,
    input  wire logic [4:0] sense_lvl,
    input  wire logic       printer_select_oe,
    input  wire logic       paper_end_oe,
    input  wire logic       busy_oe,
    input  wire logic       printer_acknowledge_oe,
    input  wire logic       printer_fault_oe,
    input  wire logic [7:0] par_data_o,
    input  wire logic [7:0] par_data_oe,
    output logic            printer_select_i,
    output logic            paper_end_i,
    output logic            busy_i,
    output logic            printer_acknowledge_i,
    output logic            printer_fault_i,
    output logic [7:0]      par_data_i
);
    // status pins idle high; low when printer or device pulls
    assign {printer_select_i, paper_end_i, busy_i, printer_acknowledge_i, printer_fault_i} =
        stat_lvl & ~{printer_select_oe, paper_end_oe, busy_oe,
                     printer_acknowledge_oe, printer_fault_oe};
    // drive pulls sense lines low; released lines float high
    assign par_data_i = (par_data_o | ~par_data_oe)
                        & {3'h7, sense_lvl};
endmodule : far_side_model

/* File: printer_floppy_pin_mux_tb.sv */
// self-checking bench for the printer / floppy pin mux
`timescale 1ns/100ps
module printer_floppy_pin_mux_tb;
    import pin_mux_pkg::*;
    logic ref_clk, reset, fdc_pullup_en;
    logic [7:0] global_port_mode_reg, parport_device_config_reg, floppy_device_config_reg;
    fdc_drive_t fdc_drive;
    fdc_sense_t fdc_sense;
    prn_ctrl_t prn_ctrl;
    prn_status_t prn_status;
    logic printer_select_i, printer_select_o, printer_select_oe, paper_end_i, paper_end_o;
    logic paper_end_oe, busy_i, busy_o, busy_oe, printer_acknowledge_i, printer_acknowledge_o;
    logic printer_acknowledge_oe, printer_fault_i, printer_fault_o, printer_fault_oe;
    logic printer_select_in_o, printer_select_in_oe, printer_initialise_o, printer_initialise_oe;
    logic printer_auto_feed_o, printer_auto_feed_oe, printer_strobe_o, printer_strobe_oe;
    logic [7:0] par_data_i, par_data_o, par_data_oe;
    logic [4:0] par_data_pullup_en, stat_lvl, sense_lvl;
    logic [9:0] pad_oe;
    int n_mismatch, check_count, cycles;

    // pull-downs gathered in drive struct order
    assign pad_oe = {par_data_oe[6], busy_oe, par_data_oe[7], printer_acknowledge_oe,
                     printer_initialise_oe, printer_select_in_oe, paper_end_oe,
                     printer_select_oe, printer_fault_oe, printer_auto_feed_oe};

    printer_floppy_pin_mux printer_floppy_pin_mux_inst (.*);
    far_side_model far_side_model_inst (.*);

    // clock
    initial begin
        ref_clk = 1'b0;
        forever #25 ref_clk = ~ref_clk;
    end

    // hang guard
    always @(posedge ref_clk) begin
        cycles <= cycles + 1;
        if (cycles == 3000) begin
            n_mismatch++;
            results();
        end
    end

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
        end
    endtask : chk

    task automatic cyc(input int n);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask : cyc

    task automatic results;
        if (n_mismatch == 0 && check_count > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask : results

    task automatic t_status;
        stat_lvl = 5'b10110;
        cyc(5);
        chk(prn_status, {5'b10110, 8'ha5});
        stat_lvl = 5'b01011;
        cyc(5);
        chk(prn_status, {5'b00001, 8'ha5});
        stat_lvl[1] = 1'b0;
        for (int i = 0; i < 8 && prn_status.ack_taken !== 1'b1; i++) cyc(1);
        chk(prn_status.ack_taken, 1'b1);
        cyc(1);
        chk(prn_status.ack_taken, 1'b0);
        stat_lvl = 5'h1f;
    endtask : t_status

    task automatic t_prn_out;
        for (int i = 0; i < 4; i++) begin
            prn_ctrl[12:9] = ~(4'h1 << i);
            cyc(2);
            chk({printer_strobe_oe, printer_auto_feed_oe, printer_select_in_oe,
                 printer_initialise_oe}, 4'h1 << i);
        end
        chk(par_data_oe, 8'hff);
        chk(par_data_o, 8'ha5);
        chk({printer_select_o, paper_end_o, busy_o, printer_acknowledge_o, printer_fault_o,
             printer_select_in_o, printer_initialise_o, printer_auto_feed_o,
             printer_strobe_o}, 9'h000);
        prn_ctrl[12:9] = 4'hf;
    endtask : t_prn_out

    task automatic t_floppy(input logic dual);
        logic [9:0] want;
        sense_lvl = 5'b10110;
        global_port_mode_reg = 8'h10;
        parport_device_config_reg = {4'h0, dual, 3'h0};
        cyc(7);
        chk(fdc_sense, 5'b01101);
        chk({printer_strobe_oe, par_data_oe[5], par_data_pullup_en}, 7'h1f);
        for (int i = 0; i < 10; i++) begin
            fdc_drive = ~(10'h1 << i);
            want      = (10'h1 << i) & (dual ? 10'h3ff : 10'h17f);
            cyc(2);
            chk(pad_oe, want);
        end
        chk(par_data_o, 8'h00);
        fdc_drive = '1;
        sense_lvl = 5'h1f;
    endtask : t_floppy

    task automatic t_back;
        fdc_drive.motor_b_on = 1'b0;
        prn_ctrl.printer_strobe = 1'b0;
        global_port_mode_reg = 8'h00;
        cyc(3);
        chk({busy_oe, printer_strobe_oe, par_data_pullup_en}, 7'h20);
        floppy_device_config_reg = 8'h80;
        cyc(2);
        chk(fdc_pullup_en, 1'b0);
        floppy_device_config_reg = 8'h00;
        cyc(2);
        chk(fdc_pullup_en, 1'b1);
    endtask : t_back

    // main sequence
    initial begin
        {n_mismatch, check_count, cycles} = '0;
        reset = 1'b1;
        {global_port_mode_reg, parport_device_config_reg, floppy_device_config_reg} = '0;
        fdc_drive = '1;
        prn_ctrl = {5'h1f, 8'ha5};
        stat_lvl = 5'h1f;
        sense_lvl = 5'h1f;
        cyc(11);
        chk({pad_oe, printer_strobe_oe, fdc_sense, fdc_pullup_en}, 17'h3f);
        cyc(1);
        reset = 1'b0;
        t_status();
        t_prn_out();
        t_floppy(1'b0);
        t_floppy(1'b1);
        t_back();
        results();
    end
endmodule : printer_floppy_pin_mux_tb
